/* File: hw/sss_top.sv */
// sync source selection register bank with AHB-Lite slave and sync event routing
`timescale 1ns/1ns
`default_nettype none
`include "sss_params.svh"
module sss_top #(
    parameter int VALUE_W = 16
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic [31:0] hrdata_out,
    output logic hresp_out,
    input wire sss_pkg::sss_pin_t pins_in,
    output sss_pkg::sss_sync_pulse_t pulses_out,
    output logic [VALUE_W-1:0] offset_out,
    output logic [VALUE_W-1:0] correction_out,
    output logic [VALUE_W-1:0] mixer_out
);
    import sss_pkg::*;

    sss_top_state_t st;
    sss_top_state_t next_st;

    logic [2:0] pin_rise;
    logic frame_ev;
    logic pin_ev;
    logic strobe_ev;
    logic sw_ev;
    logic [3:0] ev_ext;
    logic [3:0] ev_frame;
    logic ofs_load;
    logic corr_load;
    logic mix_load;
    logic nco_fire;
    logic fmt_fire;
    logic fifo_wr_fire;
    logic fifo_rd_fire;
    logic clkdiv_fire;
    logic write_now;
    logic ofs_wr;
    logic corr_wr;
    logic mix_wr;
    logic addr_ok;
    logic [VALUE_W-1:0] ofs_shadow;
    logic [VALUE_W-1:0] corr_shadow;
    logic [VALUE_W-1:0] mix_shadow;

    // any enabled event fires the action
    function automatic logic fire(input logic [3:0] mask, input logic [3:0] ev);
        fire = |(mask & ev);
    endfunction

    // writable bits take the bus data, reserved bits keep their reset value
    function automatic logic [15:0] merge(input logic [15:0] wdata, input logic [15:0] rsvd,
                                          input logic [15:0] rst);
        merge = (wdata & ~rsvd) | (rst & rsvd);
    endfunction

    sss_pin_sync #(
        .W(3)
    ) u_pin_sync (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .async_in({pins_in.frame, pins_in.sync_pin, pins_in.output_strobe_input}),
        .rise_out(pin_rise)
    );

    assign frame_ev = pin_rise[2];
    assign pin_ev = pin_rise[1];
    assign strobe_ev = pin_rise[0];
    // software sync is the rising edge of the sync bit written by software
    assign sw_ev = st.mix_sel[`SSS_SIF_BIT] & ~st.sif_prev;
    assign ev_ext = {sw_ev, pin_ev, strobe_ev, 1'b0};
    assign ev_frame = {sw_ev, pin_ev, strobe_ev, frame_ev};

    // double-buffer loads, write event taken one cycle after the shadow write
    assign ofs_load = fire(st.corr_sel[`SSS_OFS_LSB +: 4], ev_ext | {3'h0, st.wr_auto[2]});
    assign corr_load = fire(st.corr_sel[`SSS_CORR_LSB +: 4], ev_ext | {3'h0, st.wr_auto[1]});
    assign mix_load = fire(st.mix_sel[`SSS_MIXER_LSB +: 4], ev_ext | {3'h0, st.wr_auto[0]});
    assign nco_fire = fire(st.mix_sel[`SSS_NCO_LSB +: 4], ev_frame);
    assign fifo_wr_fire = fire(st.fifo_sel[`SSS_FIFO_WR_LSB +: 4], ev_frame);
    assign fifo_rd_fire = fire(st.fifo_sel[`SSS_FIFO_RD_LSB +: 4], ev_frame);

    always_comb begin
        case (st.mix_sel[`SSS_FMT_LSB +: 2])
            `SSS_FMT_FRAME: fmt_fire = frame_ev;
            `SSS_FMT_PIN: fmt_fire = pin_ev;
            default: fmt_fire = 1'b0;
        endcase
    end

    always_comb begin
        if (st.fifo_sel[`SSS_CLKDIV_BIT]) begin
            clkdiv_fire = fire(st.fifo_sel[`SSS_FIFO_WR_LSB +: 4] & `SSS_CLKDIV_SRC_MASK,
                               ev_frame);
        end else begin
            clkdiv_fire = strobe_ev;
        end
    end

    assign addr_ok = (haddr_in[31:10] == 22'h0) && (haddr_in[1:0] == 2'h0);
    assign write_now = (st.bus == SSS_BUS_WR) && st.hit;
    assign ofs_wr = write_now && (st.idx == `SSS_IDX_OFS_SHADOW);
    assign corr_wr = write_now && (st.idx == `SSS_IDX_CORR_SHADOW);
    assign mix_wr = write_now && (st.idx == `SSS_IDX_MIX_SHADOW);

    sss_dbuf #(
        .W(VALUE_W),
        .RST(VALUE_W'(`SSS_RST_SHADOW))
    ) u_ofs_buf (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .wr_en_in(ofs_wr),
        .wr_data_in(hwdata_in[VALUE_W-1:0]),
        .load_in(ofs_load),
        .shadow_out(ofs_shadow),
        .active_out(offset_out)
    );

    sss_dbuf #(
        .W(VALUE_W),
        .RST(VALUE_W'(`SSS_RST_SHADOW))
    ) u_corr_buf (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .wr_en_in(corr_wr),
        .wr_data_in(hwdata_in[VALUE_W-1:0]),
        .load_in(corr_load),
        .shadow_out(corr_shadow),
        .active_out(correction_out)
    );

    sss_dbuf #(
        .W(VALUE_W),
        .RST(VALUE_W'(`SSS_RST_SHADOW))
    ) u_mix_buf (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .wr_en_in(mix_wr),
        .wr_data_in(hwdata_in[VALUE_W-1:0]),
        .load_in(mix_load),
        .shadow_out(mix_shadow),
        .active_out(mixer_out)
    );

    always_comb begin
        next_st = st;
        if (ce_in) begin
            next_st.hresp = 1'b0;
            next_st.sif_prev = st.mix_sel[`SSS_SIF_BIT];
            next_st.wr_auto = {ofs_wr, corr_wr, mix_wr};
            next_st.pulse.nco = nco_fire;
            next_st.pulse.formatter = fmt_fire;
            next_st.pulse.fifo_wr = fifo_wr_fire;
            next_st.pulse.fifo_rd = fifo_rd_fire;
            next_st.pulse.clkdiv = clkdiv_fire;
            if (nco_fire) begin
                next_st.nco_count = st.nco_count + 16'h0001;
            end
            next_st.bus = SSS_BUS_IDLE;
            case (st.bus)
                SSS_BUS_WR: begin
                    if (st.hit) begin
                        case (st.idx)
                            `SSS_IDX_CORR_SEL: begin
                                next_st.corr_sel = merge(hwdata_in[15:0], `SSS_CORR_RSVD_MASK,
                                                         `SSS_RST_CORR_SEL);
                            end
                            `SSS_IDX_MIX_SEL: begin
                                next_st.mix_sel = merge(hwdata_in[15:0], `SSS_MIX_RSVD_MASK,
                                                        `SSS_RST_MIX_SEL);
                            end
                            `SSS_IDX_FIFO_SEL: begin
                                next_st.fifo_sel = merge(hwdata_in[15:0], `SSS_FIFO_RSVD_MASK,
                                                         `SSS_RST_FIFO_SEL);
                            end
                            default: begin
                                next_st.hresp = 1'b0;
                            end
                        endcase
                    end
                end
                SSS_BUS_RD: begin
                    next_st.hready = 1'b1;
                    next_st.hrdata = 32'h0000_0000;
                    if (st.hit) begin
                        case (st.idx)
                            `SSS_IDX_CORR_SEL: next_st.hrdata[15:0] = st.corr_sel;
                            `SSS_IDX_MIX_SEL: next_st.hrdata[15:0] = st.mix_sel;
                            `SSS_IDX_FIFO_SEL: next_st.hrdata[15:0] = st.fifo_sel;
                            `SSS_IDX_FACTORY: next_st.hrdata[15:0] = `SSS_RST_FACTORY;
                            `SSS_IDX_OFS_SHADOW: next_st.hrdata[VALUE_W-1:0] = ofs_shadow;
                            `SSS_IDX_CORR_SHADOW: next_st.hrdata[VALUE_W-1:0] = corr_shadow;
                            `SSS_IDX_MIX_SHADOW: next_st.hrdata[VALUE_W-1:0] = mix_shadow;
                            `SSS_IDX_OFS_ACTIVE: next_st.hrdata[VALUE_W-1:0] = offset_out;
                            `SSS_IDX_CORR_ACTIVE: next_st.hrdata[VALUE_W-1:0] = correction_out;
                            `SSS_IDX_MIX_ACTIVE: next_st.hrdata[VALUE_W-1:0] = mixer_out;
                            `SSS_IDX_NCO_COUNT: next_st.hrdata[15:0] = st.nco_count;
                            default: next_st.hrdata = 32'h0000_0000;
                        endcase
                    end
                end
                default: begin
                    next_st.bus = SSS_BUS_IDLE;
                end
            endcase
            // reads take one wait state so a write just before is always seen
            if (st.bus != SSS_BUS_RD && hready_in && hsel_in && htrans_in[1]) begin
                next_st.idx = haddr_in[9:2];
                next_st.hit = addr_ok;
                if (hwrite_in) begin
                    next_st.bus = SSS_BUS_WR;
                end else begin
                    next_st.bus = SSS_BUS_RD;
                    next_st.hready = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            st <= '0;
            st.bus <= SSS_BUS_IDLE;
            st.hready <= 1'b1;
            st.corr_sel <= `SSS_RST_CORR_SEL;
            st.mix_sel <= `SSS_RST_MIX_SEL;
            st.fifo_sel <= `SSS_RST_FIFO_SEL;
            st.nco_count <= `SSS_RST_COUNT;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout_out = st.hready;
    assign hrdata_out = st.hrdata;
    assign hresp_out = st.hresp;
    assign pulses_out = st.pulse;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    reset_values_a: assert property (disable iff (1'b0)
        !reset_n_in |=> st.corr_sel == 16'h1111 && st.mix_sel == 16'h1140
            && st.fifo_sel == 16'h2400)
        else $error("sync select registers missed their reset values");
    sw_offset_a: assert property (
        ce_in && st.corr_sel[15] && sw_ev |=> offset_out == $past(ofs_shadow))
        else $error("software sync did not load the offset values");
    auto_offset_a: assert property (
        ce_in && ofs_wr && st.corr_sel[12] && !ofs_load ##1 ce_in |-> ofs_load)
        else $error("write event did not load the offset values");
    pin_corr_a: assert property (
        ce_in && st.corr_sel[6] && pin_ev |=> correction_out == $past(corr_shadow))
        else $error("sync pin did not load the correction values");
    strobe_mixer_a: assert property (
        ce_in && st.mix_sel[13] && strobe_ev |=> mixer_out == $past(mix_shadow))
        else $error("strobe did not load the mixer settings");
    nco_frame_a: assert property (
        ce_in && st.mix_sel[4] && frame_ev |=> pulses_out.nco)
        else $error("frame marker did not restart the NCO");
    nco_quiet_a: assert property (
        ce_in && st.mix_sel[7:4] == 4'h0 |=> !pulses_out.nco)
        else $error("NCO restarted with an empty mask");
    fmt_off_a: assert property (
        ce_in && st.mix_sel[3] |=> !pulses_out.formatter)
        else $error("formatter synced while its sync is off");
    fmt_pin_a: assert property (
        ce_in && st.mix_sel[3:2] == 2'h1 |=> pulses_out.formatter == $past(pin_ev))
        else $error("formatter did not follow the sync pin");
    fifo_sides_a: assert property (
        ce_in && st.fifo_sel[15:8] == 8'h24 |=>
            pulses_out.fifo_wr == $past(strobe_ev) && pulses_out.fifo_rd == $past(pin_ev))
        else $error("fifo sync sides did not follow their masks");
    clkdiv_strobe_a: assert property (
        ce_in && !st.fifo_sel[0] |=> pulses_out.clkdiv == $past(strobe_ev))
        else $error("clock dividers did not follow the strobe");
    clkdiv_nostrobe_a: assert property (
        ce_in && st.fifo_sel[0] && !pin_ev && !frame_ev && !sw_ev |=> !pulses_out.clkdiv)
        else $error("clock dividers synced from the strobe in fifo mode");
    read_wait_a: assert property (
        ce_in && hready_in && hsel_in && htrans_in[1] && !hwrite_in && st.bus != SSS_BUS_RD
            |=> !hreadyout_out ##1 (hreadyout_out || !$past(ce_in)))
        else $error("read wait state missing");
    // bus, freeze and remaining source checks
    fmt_frame_a: assert property (
        ce_in && st.mix_sel[3:2] == 2'h0 |=> pulses_out.formatter == $past(frame_ev))
        else $error("formatter did not follow the frame marker");
    fifo_rd_frame_a: assert property (
        ce_in && st.fifo_sel[8] && frame_ev |=> pulses_out.fifo_rd)
        else $error("frame marker did not sync the fifo read side");
    nco_sw_a: assert property (
        ce_in && st.mix_sel[7] && sw_ev |=> pulses_out.nco)
        else $error("software sync did not restart the NCO");
    clkdiv_sw_a: assert property (
        ce_in && st.fifo_sel[0] && st.fifo_sel[15] && sw_ev |=> pulses_out.clkdiv)
        else $error("software sync did not reach the clock dividers");
    write_nowait_a: assert property (
        ce_in && hready_in && hsel_in && htrans_in[1] && hwrite_in && st.bus != SSS_BUS_RD
            |=> hreadyout_out)
        else $error("write took a wait state");
    okay_resp_a: assert property (
        hresp_out == 1'b0)
        else $error("slave answered with an error response");
    ce_freeze_a: assert property (
        !ce_in |=> st == $past(st))
        else $error("state changed while the clock enable was low");

    nco_seen_c: cover property (ce_in && nco_fire);
    fmt_pin_c: cover property (ce_in && fmt_fire && st.mix_sel[3:2] == 2'h1);
    auto_load_c: cover property (ce_in && st.wr_auto[2] && ofs_load);
    clkdiv_fifo_c: cover property (ce_in && st.fifo_sel[0] && clkdiv_fire);
    sw_sync_c: cover property (ce_in && sw_ev && mix_load);
endmodule
`default_nettype wire

/* File: hw/sss_params.svh */
// offsets, field positions and reset values of the sync source selection block
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH

// register indices; the byte address is four times the index
`define SSS_IDX_CORR_SEL 8'h1E
`define SSS_IDX_MIX_SEL 8'h1F
`define SSS_IDX_FIFO_SEL 8'h20
`define SSS_IDX_FACTORY 8'h21
`define SSS_IDX_OFS_SHADOW 8'h24
`define SSS_IDX_CORR_SHADOW 8'h25
`define SSS_IDX_MIX_SHADOW 8'h26
`define SSS_IDX_OFS_ACTIVE 8'h28
`define SSS_IDX_CORR_ACTIVE 8'h29
`define SSS_IDX_MIX_ACTIVE 8'h2A
`define SSS_IDX_NCO_COUNT 8'h2B

// reset values
`define SSS_RST_CORR_SEL 16'h1111
`define SSS_RST_MIX_SEL 16'h1140
`define SSS_RST_FIFO_SEL 16'h2400
`define SSS_RST_FACTORY 16'h0000
`define SSS_RST_SHADOW 16'h0000
`define SSS_RST_COUNT 16'h0000

// reserved bits hold their reset value whatever is written
`define SSS_CORR_RSVD_MASK 16'h0F0F
`define SSS_MIX_RSVD_MASK 16'h0F01
`define SSS_FIFO_RSVD_MASK 16'h00FE

// field positions
`define SSS_OFS_LSB 12
`define SSS_CORR_LSB 4
`define SSS_MIXER_LSB 12
`define SSS_NCO_LSB 4
`define SSS_FMT_LSB 2
`define SSS_SIF_BIT 1
`define SSS_FIFO_WR_LSB 12
`define SSS_FIFO_RD_LSB 8
`define SSS_CLKDIV_BIT 0

// event positions within every four-bit mask
`define SSS_EV_SW 3
`define SSS_EV_PIN 2
`define SSS_EV_STROBE 1
`define SSS_EV_LOCAL 0

// formatter source codes
`define SSS_FMT_FRAME 2'h0
`define SSS_FMT_PIN 2'h1

// clock divider path drops the strobe bit of the fifo write mask
`define SSS_CLKDIV_SRC_MASK 4'hD

`endif

/* File: hw/sss_pkg.sv */
// types shared by the sync source selection block
package sss_pkg;

    typedef enum logic [2:0] {
        SSS_BUS_IDLE = 3'b001,
        SSS_BUS_WR = 3'b010,
        SSS_BUS_RD = 3'b100
    } sss_bus_state_t;

    typedef struct packed {
        logic frame;
        logic sync_pin;
        logic output_strobe_input;
    } sss_pin_t;

    typedef struct packed {
        logic nco;
        logic formatter;
        logic fifo_wr;
        logic fifo_rd;
        logic clkdiv;
    } sss_sync_pulse_t;

    typedef struct packed {
        sss_bus_state_t bus;
        logic [7:0] idx;
        logic hit;
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
        logic [15:0] corr_sel;
        logic [15:0] mix_sel;
        logic [15:0] fifo_sel;
        logic sif_prev;
        logic [2:0] wr_auto;
        sss_sync_pulse_t pulse;
        logic [15:0] nco_count;
    } sss_top_state_t;

endpackage

/* File: hw/sss_pin_sync.sv */
// two-flop synchroniser with rising-edge pulse for the sync pins
`timescale 1ns/1ns
`default_nettype none
module sss_pin_sync #(
    parameter int W = 3
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] rise_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
        logic [W-1:0] prev;
        logic [W-1:0] rise;
    } sss_pin_sync_state_t;

    sss_pin_sync_state_t st;
    sss_pin_sync_state_t next_st;

    always_comb begin
        next_st = st;
        if (ce_in) begin
            next_st.meta = async_in;
            next_st.stable = st.meta;
            next_st.prev = st.stable;
            next_st.rise = st.stable & ~st.prev;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rise_out = st.rise;

    pulse_one_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ce_in && (st.rise != '0) |=> ((st.rise & $past(st.rise)) == '0))
        else $error("sync pin pulse lasted more than one cycle");
endmodule
`default_nettype wire

/* File: hw/sss_dbuf.sv */
// double-buffered word: shadow takes writes, active takes the shadow on load
`timescale 1ns/1ns
`default_nettype none
module sss_dbuf #(
    parameter int W = 16,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic wr_en_in,
    input wire logic [W-1:0] wr_data_in,
    input wire logic load_in,
    output logic [W-1:0] shadow_out,
    output logic [W-1:0] active_out
);
    typedef struct packed {
        logic [W-1:0] shadow;
        logic [W-1:0] active;
    } sss_dbuf_state_t;

    sss_dbuf_state_t st;
    sss_dbuf_state_t next_st;

    always_comb begin
        next_st = st;
        if (ce_in) begin
            if (wr_en_in) begin
                next_st.shadow = wr_data_in;
            end
            if (load_in) begin
                next_st.active = st.shadow;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            st <= {RST, RST};
        end else begin
            st <= next_st;
        end
    end

    assign shadow_out = st.shadow;
    assign active_out = st.active;

    load_copy_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ce_in && load_in |=> st.active == $past(st.shadow))
        else $error("active value did not take the shadow on load");
    active_hold_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        !(ce_in && load_in) |=> $stable(st.active))
        else $error("active value changed without a sync event");
endmodule
`default_nettype wire

/* File: tb/sss_src_model.sv */
// data source model driving frame, sync pin and output strobe levels
`timescale 1ns/1ns
`default_nettype none
module sss_src_model (
    input wire logic sys_clk_in,
    output sss_pkg::sss_pin_t pins_out
);
    import sss_pkg::*;
    int hold = 0;
    initial pins_out = '0;
    // one rising edge, held for a varying time, then low long enough to be seen again
    task automatic fire(input int b);
        @(posedge sys_clk_in);
        pins_out[b] <= 1'b1;
        hold = hold % 3 + 1;
        repeat (hold) @(posedge sys_clk_in);
        pins_out[b] <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
    endtask
endmodule
`default_nettype wire

/* File: tb/sync_source_selection_tb.sv */
// self-checking bench for the sync source selection block
`timescale 1ns/1ns
`default_nettype none
`include "sss_params.svh"
module sync_source_selection_tb;
    import sss_pkg::*;
    logic sys_clk_in, reset_n_in, ce_in, hsel, hwrite, rd_dp, hreadyout, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    sss_pin_t pins;
    sss_sync_pulse_t pulses;
    logic [15:0] ofs, corr, mix;
    logic [31:0] rd_q[$];
    logic [4:0] ev_q[$];
    logic [31:0] v[6];
    int bad_count = 0;
    int checks = 0;
    int seed = 72;

    sss_top dut_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout), .hreadyout_out(hreadyout),
        .hrdata_out(hrdata), .hresp_out(hresp), .pins_in(pins), .pulses_out(pulses),
        .offset_out(ofs), .correction_out(corr), .mixer_out(mix));
    sss_src_model src_u (.sys_clk_in(sys_clk_in), .pins_out(pins));

    function automatic logic [31:0] adr(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !wr;
        do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // pin index: 2 frame, 1 sync pin, 0 strobe; e is the pulse set expected
    task automatic ev(input int b, input logic [4:0] e);
        if (e != 5'h0) begin
            ev_q.push_back(e);
        end
        src_u.fire(b);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // monitor: read data and every pulse set against the oldest note
    always @(posedge sys_clk_in) begin
        if (rd_dp && hreadyout) begin
            chk(hrdata, rd_q.pop_front());
            chk({31'h0, hresp}, 32'h0);
        end
        if (reset_n_in && pulses !== 5'h0) begin
            chk({27'h0, pulses}, ev_q.size() ? {27'h0, ev_q.pop_front()} : 32'h0);
        end
    end

    initial begin
        sys_clk_in = 1'b0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end

    initial begin
        repeat (20000) @(posedge sys_clk_in);
        bad_count++;
        test_done();
    end

    initial begin
        reset_n_in = 1'b0;
        ce_in = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        rd_dp = 1'b0;
        for (int i = 0; i < 6; i++) v[i] = $random(seed);
        repeat (8) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        rd(adr(`SSS_IDX_CORR_SEL), 32'h1111);
        rd(adr(`SSS_IDX_MIX_SEL), 32'h1140);
        rd(adr(`SSS_IDX_FIFO_SEL), 32'h2400);
        rd(adr(`SSS_IDX_FACTORY), 32'h0);
        rd(32'h200, 32'h0);
        // shadow writes load at once through the write event
        wr(adr(`SSS_IDX_OFS_SHADOW), v[0]);
        wr(adr(`SSS_IDX_CORR_SHADOW), v[1]);
        wr(adr(`SSS_IDX_MIX_SHADOW), v[2]);
        rd(adr(`SSS_IDX_OFS_ACTIVE), {16'h0, v[0][15:0]});
        rd(adr(`SSS_IDX_CORR_ACTIVE), {16'h0, v[1][15:0]});
        rd(adr(`SSS_IDX_MIX_ACTIVE), {16'h0, v[2][15:0]});
        chk({16'h0, ofs}, {16'h0, v[0][15:0]});
        chk({16'h0, corr}, {16'h0, v[1][15:0]});
        chk({16'h0, mix}, {16'h0, v[2][15:0]});
        // software sync only: shadows wait for the sync bit
        wr(adr(`SSS_IDX_CORR_SEL), 32'h8080);
        rd(adr(`SSS_IDX_CORR_SEL), 32'h8181);
        wr(adr(`SSS_IDX_OFS_SHADOW), v[3]);
        wr(adr(`SSS_IDX_CORR_SHADOW), v[4]);
        rd(adr(`SSS_IDX_OFS_ACTIVE), {16'h0, v[0][15:0]});
        wr(adr(`SSS_IDX_MIX_SEL), 32'h1142);
        wr(adr(`SSS_IDX_MIX_SEL), 32'h1140);
        rd(adr(`SSS_IDX_OFS_ACTIVE), {16'h0, v[3][15:0]});
        rd(adr(`SSS_IDX_CORR_ACTIVE), {16'h0, v[4][15:0]});
        // strobe loads the correction and hits the default fifo and divider paths
        wr(adr(`SSS_IDX_CORR_SEL), 32'h6060);
        wr(adr(`SSS_IDX_CORR_SHADOW), v[5]);
        wr(adr(`SSS_IDX_MIX_SEL), 32'h3140);
        ev(0, 5'h05);
        rd(adr(`SSS_IDX_CORR_ACTIVE), {16'h0, v[5][15:0]});
        // every formatter code, nco mask on pin and frame
        for (int c = 0; c < 4; c++) begin
            wr(adr(`SSS_IDX_MIX_SEL), 32'h1150 + 32'(4 * c));
            ev(1, 5'h12 | (c == 1 ? 5'h08 : 5'h00));
            ev(2, 5'h10 | (c == 0 ? 5'h08 : 5'h00));
        end
        // divider follows the write mask sources except the strobe in mode one
        wr(adr(`SSS_IDX_MIX_SEL), 32'h1140);
        wr(adr(`SSS_IDX_FIFO_SEL), 32'hF501);
        rd(adr(`SSS_IDX_FIFO_SEL), 32'hF501);
        ev(2, 5'h0F);
        ev(1, 5'h17);
        ev(0, 5'h04);
        // software sync reaches nco, fifo write side and divider together
        wr(adr(`SSS_IDX_MIX_SEL), 32'h11C0);
        ev_q.push_back(5'h15);
        wr(adr(`SSS_IDX_MIX_SEL), 32'h11C2);
        wr(adr(`SSS_IDX_MIX_SEL), 32'h11C0);
        rd(adr(`SSS_IDX_NCO_COUNT), 32'h0000_000A);
        // clock enable low: a write is not taken and nothing moves
        ce_in <= 1'b0;
        wr(adr(`SSS_IDX_OFS_SHADOW), 32'h0000_5A5A);
        ce_in <= 1'b1;
        rd(adr(`SSS_IDX_OFS_SHADOW), {16'h0, v[3][15:0]});
        // reset in mid-run brings back the reset values
        reset_n_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        rd(adr(`SSS_IDX_CORR_SEL), 32'h1111);
        rd(adr(`SSS_IDX_OFS_ACTIVE), 32'h0);
        repeat (10) @(posedge sys_clk_in);
        chk(32'(ev_q.size()), 32'h0);
        chk(32'(rd_q.size()), 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
